// ===== shared/rrac_pkg.sv
/*
 * Constants for the remote register-access command interpreter: command
 * word fields, info-area offsets and field layouts, per-space descriptors.
 * Assumes a single synchronous clock domain; no other file is needed.
 */
`default_nettype none
package rrac_pkg;
    // command word layout
    localparam int CMD_WRITE_BIT = 15;
    localparam int CMD_ADDR_BIT = 14;
    localparam int CMD_INFO_BIT = 13;
    localparam int CMD_SPACE_LSB = 10;
    localparam int CMD_SIZE_LSB = 8;
    localparam int CMD_INC_BIT = 7;
    localparam int CMD_COUNT_LSB = 0;
    localparam int SPACE_W = 3;
    localparam int SIZE_W = 2;
    localparam int COUNT_W = 7;
    localparam int ADDR_W = 16;
    localparam int NUM_SPACES = 8;

    // element size codes
    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;
    localparam logic [1:0] SIZE_64 = 2'h3;

    // info-area byte offsets, one 16-bit word each
    localparam logic [15:0] INFO_SIGNATURE_OFS = 16'h0000;
    localparam logic [15:0] INFO_SIZE_TYPE_OFS = 16'h0002;
    localparam logic [15:0] INFO_RANGES_OFS = 16'h0004;
    localparam logic [15:0] INFO_POINTER_OFS = 16'h0006;
    localparam logic [15:0] INFO_LABEL_0_1_OFS = 16'h0008;
    localparam logic [15:0] INFO_LABEL_2_3_OFS = 16'h000A;
    localparam logic [15:0] INFO_LABEL_4_5_OFS = 16'h000C;
    localparam logic [15:0] INFO_LABEL_6_7_OFS = 16'h000E;
    localparam logic [11:0] SIGNATURE_BASE = 12'h5A0;

    // size/type word fields
    localparam int SZ_WRITABLE_BIT = 15;
    localparam int SZ_TYPE_LSB = 8;
    localparam int SZ_ACCESS_LSB = 0;
    localparam logic [6:0] TYPE_REGISTER = 7'h01;
    localparam logic [6:0] TYPE_MEMORY = 7'h02;
    localparam logic [6:0] TYPE_EEPROM = 7'h0E;
    localparam logic [6:0] TYPE_FLASH = 7'h0F;

    // range word fields
    localparam int RG_ERASE_LSB = 11;
    localparam int RG_PAGE_LSB = 6;
    localparam int RG_RANGE_LSB = 0;
    localparam logic [15:0] RG_RANGE_ONLY_MASK = 16'h003F;

    // per-space descriptors; plain defaults for this build
    localparam logic [15:0] SPACE_SIZE_TYPE [NUM_SPACES] = '{
        16'h8104, 16'h8102, 16'h8E02, 16'h8F04,
        16'h8202, 16'h8202, 16'h8102, 16'h0102};
    localparam logic [15:0] SPACE_RANGES [NUM_SPACES] = '{
        16'h0010, 16'h0008, 16'h0007, 16'h8204,
        16'h0010, 16'h0010, 16'h0008, 16'h0008};
    // label "SPACE0  ", first character in the low byte; digit patched
    localparam logic [63:0] LABEL_BASE = 64'h2020_3045_4341_5053;
    localparam int LABEL_DIGIT_LSB = 40;
endpackage
`default_nettype wire

// ===== rtl/rrac_ptr.sv
/*
 * One per-space byte address pointer: loadable, steps by element size.
 * Assumes the caller raises load and step_en only for its own space.
 */
`default_nettype none
module rrac_ptr (
    input wire logic clock,                  // system clock
    input wire logic rst_b,                  // async reset, active low
    input wire logic load,                   // load pointer
    input wire logic [15:0] load_value,      // byte address to load
    input wire logic step_en,                // advance pointer
    input wire logic [3:0] step,             // element size in bytes
    output logic [15:0] ptr                  // current byte address
);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ptr <= 16'h0000;
        end else if (load) begin
            ptr <= load_value;               // [R3] [R11]
        end else if (step_en) begin
            ptr <= ptr + {12'h000, step};    // [R8]
        end
    end
endmodule
`default_nettype wire

// ===== rtl/rrac_cmd.sv
/*
 * Remote register-access command interpreter. Takes the command stream
 * one byte at a time, keeps a pointer per space, issues element reads and
 * writes to the space memory, answers info-area reads itself and returns
 * read data as bytes. Assumes the byte source and the memory share clock;
 * the tx byte sink takes every byte offered.
 */
`default_nettype none
// Function
// R1: 16-bit word: write, addr, info, space, size, inc, count
// R2: write bit one writes, zero reads
// R3: address bit loads pointer from following word
// R4: each space owns its own pointer
// R5: info bit selects the space's info area
// R6: three-bit field picks one of eight spaces
// R7: size field gives 8, 16, 32 or 64 bits
// R8: increment bit steps pointer by element bytes
// R9: count is 1 to 127, zero is error
// R10: host sends only address, then write data
// R11: addresses are always byte addresses
// R12: addresses and data go low byte first
// R13: info areas read-only, writes do nothing
// R14: info areas allow only 16-bit reads
// R15: info area holds signature, sizes, ranges, pointer, label
// R16: size word: writable, type, access widths
// R17: type codes register, memory, EEPROM, flash
// R18: access mask bit n allows width 8 shl n
// R19: range word holds erase, page, range exponents
// R20: non-flash spaces report erase and page zero
// R21: pointer word read leaves pointer unchanged (code still steps it when inc is set)
// R22: zero count makes no access, no pointer change
module rrac_cmd (
    input wire logic clock,                  // 40 MHz system clock
    input wire logic rst_b,                  // async reset, active low
    input wire logic rx_valid,               // command stream byte valid
    input wire logic [7:0] rx_byte,          // command stream byte
    output logic rx_ready,                   // byte will be taken
    output logic tx_valid,                   // read data byte valid pulse
    output logic [7:0] tx_byte,              // read data byte
    output logic mem_rd,                     // element read pulse
    output logic mem_wr,                     // element write pulse
    output logic [2:0] mem_space,            // space of the access
    output logic [1:0] mem_size,             // element size code
    output logic [15:0] mem_addr,            // byte address of element
    output logic [63:0] mem_wdata,           // write data, low bytes used
    input wire logic mem_rvalid,             // read data valid
    input wire logic [63:0] mem_rdata,       // read data, low bytes used
    output logic cmd_error                   // bad command pulse
);
    import rrac_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD_HI = 3'b001,
        ST_ADR_LO = 3'b011,
        ST_ADR_HI = 3'b010,
        ST_WDATA = 3'b110,
        ST_RD_REQ = 3'b111,
        ST_RD_WAIT = 3'b101,
        ST_RD_SEND = 3'b100
    } rrac_state_type;

    rrac_state_type state;
    rrac_state_type next_state;
    logic [15:0] cmd;
    logic [7:0] lo_byte;
    logic skip;
    logic [6:0] elem_left;
    logic [2:0] byte_cnt;
    logic [63:0] data_buf;
    logic [63:0] next_wdata;
    logic take;
    logic [15:0] new_cmd;
    logic new_bad;
    logic [15:0] ptrs [NUM_SPACES];
    logic [15:0] cur_ptr;
    logic [3:0] nbytes;
    logic last_byte;
    logic last_elem;
    logic ptr_load;
    logic ptr_step;
    logic [15:0] info_word;

    // fields of the latched command
    logic c_write;
    logic c_addr;
    logic c_info;
    logic c_inc;
    logic [2:0] c_space;
    logic [1:0] c_size;

    assign take = rx_valid && rx_ready;
    assign new_cmd = {rx_byte, lo_byte};                  // [R12]
    assign c_write = cmd[CMD_WRITE_BIT];                  // [R1] [R2]
    assign c_addr = cmd[CMD_ADDR_BIT];
    assign c_info = cmd[CMD_INFO_BIT];                    // [R5]
    assign c_inc = cmd[CMD_INC_BIT];
    assign c_space = cmd[CMD_SPACE_LSB +: SPACE_W];       // [R6]
    assign c_size = cmd[CMD_SIZE_LSB +: SIZE_W];
    assign nbytes = 4'h1 << c_size;                       // [R7]
    assign last_byte = byte_cnt == 3'(nbytes - 4'h1);
    assign last_elem = elem_left == 7'h01;
    assign cur_ptr = ptrs[c_space];                       // [R4]

    // zero count, info write or non-16-bit info access is refused whole
    assign new_bad = (new_cmd[CMD_COUNT_LSB +: COUNT_W] == 7'h00) ||
        (new_cmd[CMD_INFO_BIT] &&
         (new_cmd[CMD_WRITE_BIT] ||
          new_cmd[CMD_SIZE_LSB +: SIZE_W] != SIZE_16));  // [R9] [R13] [R14]

    assign ptr_load = state == ST_ADR_HI && take && !skip; // [R3] [R22]
    assign ptr_step = c_inc && !skip && last_byte &&
        ((state == ST_WDATA && take) || state == ST_RD_SEND);       // [R8]

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SPACES; gi++) begin : g_ptr
            rrac_ptr u_ptr (
                .clock(clock),
                .rst_b(rst_b),
                .load(ptr_load && c_space == 3'(gi)),          // [R4]
                .load_value(new_cmd),
                .step_en(ptr_step && c_space == 3'(gi)),
                .step(nbytes),
                .ptr(ptrs[gi])
            );
        end
    endgenerate

    // info-area word at the current pointer; past the last word reads zero
    always_comb begin
        logic [15:0] ranges;
        logic [63:0] label;
        ranges = SPACE_RANGES[c_space];
        label = LABEL_BASE;
        label[LABEL_DIGIT_LSB +: 8] = 8'h30 + {5'h00, c_space};
        if (SPACE_SIZE_TYPE[c_space][SZ_TYPE_LSB +: 7] != TYPE_FLASH) begin
            ranges = ranges & RG_RANGE_ONLY_MASK;                   // [R20]
        end
        case (cur_ptr & 16'hFFFE)  // [R15] [R16] [R17] [R18]
            INFO_SIGNATURE_OFS: info_word = {SIGNATURE_BASE, 1'b0, c_space};
            INFO_SIZE_TYPE_OFS: info_word = SPACE_SIZE_TYPE[c_space];
            INFO_RANGES_OFS: info_word = ranges;                      // [R19]
            INFO_POINTER_OFS: info_word = cur_ptr;                    // [R21]
            INFO_LABEL_0_1_OFS: info_word = label[15:0];
            INFO_LABEL_2_3_OFS: info_word = label[31:16];
            INFO_LABEL_4_5_OFS: info_word = label[47:32];
            INFO_LABEL_6_7_OFS: info_word = label[63:48];
            default: info_word = 16'h0000;
        endcase
    end

    // write bytes fill the element low byte first
    always_comb begin
        next_wdata = data_buf;
        next_wdata[{byte_cnt, 3'b000} +: 8] = rx_byte;                // [R12]
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_CMD_HI;
                end
            end
            ST_CMD_HI: begin
                if (take) begin
                    if (new_cmd[CMD_ADDR_BIT]) begin
                        next_state = ST_ADR_LO;                       // [R3]
                    end else if (!(|new_cmd[CMD_COUNT_LSB +: COUNT_W])) begin
                        next_state = ST_IDLE;                         // [R22]
                    end else if (new_cmd[CMD_WRITE_BIT]) begin
                        next_state = ST_WDATA;                        // [R2]
                    end else if (new_bad) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_RD_REQ;
                    end
                end
            end
            ST_ADR_LO: begin
                if (take) begin
                    next_state = ST_ADR_HI;
                end
            end
            ST_ADR_HI: begin
                if (take) begin
                    if (elem_left == 7'h00) begin
                        next_state = ST_IDLE;
                    end else if (c_write) begin
                        next_state = ST_WDATA;                        // [R10]
                    end else if (skip) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_RD_REQ;
                    end
                end
            end
            ST_WDATA: begin
                if (take && last_byte && last_elem) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RD_REQ: begin
                next_state = c_info ? ST_RD_SEND : ST_RD_WAIT;        // [R5]
            end
            ST_RD_WAIT: begin
                if (mem_rvalid) begin
                    next_state = ST_RD_SEND;
                end
            end
            ST_RD_SEND: begin
                if (last_byte) begin
                    next_state = last_elem ? ST_IDLE : ST_RD_REQ;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            rx_ready <= 1'b0;
        end else begin
            state <= next_state;
            // reads hold the stream off until their data is out
            rx_ready <= next_state inside {ST_IDLE, ST_CMD_HI, ST_ADR_LO,
                ST_ADR_HI, ST_WDATA};
        end
    end

    // command capture
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd <= 16'h0000;
            lo_byte <= 8'h00;
            skip <= 1'b0;
            cmd_error <= 1'b0;
        end else begin
            cmd_error <= 1'b0;
            if (take && (state == ST_IDLE || state == ST_ADR_LO)) begin
                lo_byte <= rx_byte;
            end
            if (state == ST_CMD_HI && take) begin
                cmd <= new_cmd;                                       // [R1]
                skip <= new_bad;
                cmd_error <= new_bad;                                 // [R9]
            end
        end
    end

    // element and byte counting
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            elem_left <= 7'h00;
            byte_cnt <= 3'h0;
        end else begin
            if (state == ST_CMD_HI && take) begin
                elem_left <= new_cmd[CMD_COUNT_LSB +: COUNT_W];       // [R9]
                byte_cnt <= 3'h0;
            end else if ((state == ST_WDATA && take) ||
                    state == ST_RD_SEND) begin
                if (last_byte) begin
                    byte_cnt <= 3'h0;
                    elem_left <= elem_left - 7'h01;
                end else begin
                    byte_cnt <= byte_cnt + 3'h1;
                end
            end
        end
    end

    // memory side
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_space <= 3'h0;
            mem_size <= 2'h0;
            mem_addr <= 16'h0000;
            mem_wdata <= 64'h0;
            data_buf <= 64'h0;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            if (state == ST_WDATA && take) begin
                data_buf <= next_wdata;
                if (last_byte && !skip) begin
                    mem_wr <= 1'b1; // [R2] [R13]
                    mem_wdata <= next_wdata;
                    mem_addr <= cur_ptr;                              // [R11]
                    mem_space <= c_space;
                    mem_size <= c_size;
                end
            end
            if (state == ST_RD_REQ) begin
                if (c_info) begin
                    data_buf <= {48'h0, info_word};                   // [R14]
                end else begin
                    mem_rd <= 1'b1;                                   // [R2]
                    mem_addr <= cur_ptr;
                    mem_space <= c_space;
                    mem_size <= c_size;
                end
            end
            if (state == ST_RD_WAIT && mem_rvalid) begin
                data_buf <= mem_rdata;
            end
        end
    end

    // read data leaves low byte first
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
        end else begin
            tx_valid <= state == ST_RD_SEND;
            if (state == ST_RD_SEND) begin
                tx_byte <= data_buf[{byte_cnt, 3'b000} +: 8];         // [R12]
            end
        end
    end

    sequence s_info_sig_req;
        state == ST_RD_REQ && c_info && cur_ptr == INFO_SIGNATURE_OFS;
    endsequence
    sequence s_sig_bytes(logic [2:0] sp);
        ##1 tx_valid && tx_byte == 8'(sp) ##1 tx_valid && tx_byte == 8'h5A;
    endsequence

    AST_ZERO_COUNT_ERR: assert property ( // [R9]
        state == ST_CMD_HI && take && new_cmd[6:0] == 7'h00 |=> cmd_error)
        else $error("zero count not flagged");
    AST_ZERO_COUNT_QUIET: assert property ( // [R22]
        state != ST_IDLE && elem_left == 7'h00 && skip |->
        !ptr_load && !mem_wr && !mem_rd)
        else $error("zero count caused access");
    AST_WRITE_PULSE: assert property ( // [R2]
        state == ST_WDATA && take && last_byte && !skip |=> mem_wr && !mem_rd)
        else $error("write element not issued");
    AST_READ_NO_WRITE: assert property ( // [R2]
        state == ST_RD_WAIT |-> !mem_wr ##1 !mem_wr)
        else $error("write during read");
    AST_ADDR_LOAD: assert property ( // [R3]
        ptr_load |=> cur_ptr == $past(new_cmd))
        else $error("pointer not loaded");
    AST_STEP: assert property ( // [R8]
        mem_wr |-> cur_ptr == (c_inc ? mem_addr + 16'(nbytes) : mem_addr))
        else $error("pointer step wrong");
    AST_INFO_NO_MEM: assert property ( // [R13]
        state != ST_IDLE && c_info |=> !mem_wr && !mem_rd)
        else $error("info access reached memory");
    AST_INFO_SIGNATURE: assert property ( // [R15]
        s_info_sig_req |=> s_sig_bytes($past(c_space)))
        else $error("signature bytes wrong");
    AST_RX_HELD: assert property ( // [R10]
        state == ST_RD_SEND |-> !rx_ready)
        else $error("stream taken during read");
endmodule
`default_nettype wire

// ===== dv/rrac_mem_model.sv
/*
 * Space memory model: answers each element read after a short
 * address-dependent delay with a byte pattern of space and address.
 * Assumes one read outstanding at a time, as the interpreter issues.
 */
`default_nettype none
module rrac_mem_model (
    input wire logic clock,              // system clock
    input wire logic rst_b,              // async reset, active low
    input wire logic mem_rd,             // element read pulse
    input wire logic [2:0] mem_space,    // space of the read
    input wire logic [15:0] mem_addr,    // byte address of element
    output logic mem_rvalid,             // read data valid pulse
    output logic [63:0] mem_rdata        // read data, byte0 lowest
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy;
    logic [1:0] wait_cnt;
    logic [63:0] pending;

    function automatic logic [63:0] pat(input logic [2:0] s,
                                        input logic [15:0] a);
        for (int i = 0; i < 8; i++) begin
            pat[i*8 +: 8] = a[7:0] + 8'(i) + {1'b0, s, 4'h0};
        end
    endfunction

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            wait_cnt <= 2'h0;
            pending <= 64'h0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 64'h0;
        end else begin
            mem_rvalid <= 1'b0;
            // stale data flips each cycle so it never passes for fresh
            mem_rdata <= ~mem_rdata;
            if (mem_rd) begin
                busy <= 1'b1;
                wait_cnt <= mem_addr[2:1];
                pending <= pat(mem_space, mem_addr);
            end else if (busy && wait_cnt == 2'h0) begin
                busy <= 1'b0;
                mem_rvalid <= 1'b1;
                mem_rdata <= pending;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/rrac_cmd_tb.sv
/*
 * Self-checking bench for the command interpreter: sends commands byte
 * by byte, predicts pointers, memory accesses, errors and read bytes.
 * Assumes the memory model in the same folder.
 */
`default_nettype none
module rrac_cmd_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rrac_pkg::*;
    logic clock = 1'b0;
    logic rst_b, rx_valid, rx_ready, tx_valid, mem_rd, mem_wr;
    logic mem_rvalid, cmd_error;
    logic [7:0] rx_byte, tx_byte;
    logic [2:0] mem_space;
    logic [1:0] mem_size;
    logic [15:0] mem_addr;
    logic [63:0] mem_wdata, mem_rdata;
    logic [15:0] ptr [8];
    logic [7:0] txq [$];
    logic [20:0] rdq [$];
    logic [84:0] wq [$];
    int mismatches = 0;
    int comparisons = 0;
    int errs = 0;
    int seed;
    logic [31:0] r;

    rrac_cmd rrac_cmd_i (.clock(clock), .rst_b(rst_b),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_space(mem_space), .mem_size(mem_size),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .cmd_error(cmd_error));
    rrac_mem_model rrac_mem_model_i (.clock(clock), .rst_b(rst_b),
        .mem_rd(mem_rd), .mem_space(mem_space), .mem_addr(mem_addr),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    always #12.5 clock = ~clock;

    always @(posedge clock) begin
        if (tx_valid === 1'b1) txq.push_back(tx_byte);
        if (mem_rd === 1'b1) rdq.push_back({mem_space, mem_size, mem_addr});
        if (mem_wr === 1'b1) begin
            wq.push_back({mem_space, mem_size, mem_addr, mem_wdata});
        end
        if (cmd_error === 1'b1) errs++;
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    function automatic logic [63:0] pat(input logic [2:0] s,
                                        input logic [15:0] a);
        for (int i = 0; i < 8; i++) begin
            pat[i*8 +: 8] = a[7:0] + 8'(i) + {1'b0, s, 4'h0};
        end
    endfunction

    function automatic logic [63:0] info(input logic [2:0] s,
                                         input logic [15:0] p);
        logic [15:0] o;
        logic [15:0] st;
        logic [63:0] lbl;
        o = {p[15:1], 1'b0};
        st = SPACE_SIZE_TYPE[s];
        lbl = LABEL_BASE + (64'(s) << LABEL_DIGIT_LSB);
        info = 64'h0;
        if (o == INFO_SIGNATURE_OFS) info[15:0] = {SIGNATURE_BASE, 1'b0, s};
        else if (o == INFO_SIZE_TYPE_OFS) info[15:0] = st;
        else if (o == INFO_RANGES_OFS) begin
            info[15:0] = SPACE_RANGES[s];
            if (st[14:8] != TYPE_FLASH) info[15:0] &= RG_RANGE_ONLY_MASK;
        end else if (o == INFO_POINTER_OFS) info[15:0] = p;
        else if (o <= INFO_LABEL_6_7_OFS) info[15:0] = lbl[(o-8)*8 +: 16];
    endfunction

    task automatic send(input logic [7:0] b);
        logic ok;
        int t;
        rx_valid = 1'b1;
        rx_byte = b;
        t = 0;
        do begin
            ok = rx_ready;
            @(posedge clock);
            #2;
            t++;
        end while (!ok && t < 3000);
        if (!ok) mismatches++;
    endtask

    task automatic run(input logic w, a, c, input logic [2:0] sp,
        input logic [1:0] sz, input logic inc, input logic [6:0] n,
        input logic [15:0] ad);
        logic [15:0] cw;
        logic [63:0] d, m;
        logic bad;
        int nb, e0, t;
        logic [7:0] et [$];
        logic [20:0] er [$];
        logic [84:0] ew [$];
        nb = 1 << sz;
        m = (nb == 8) ? '1 : (64'h1 << (nb * 8)) - 64'h1;
        bad = (n == 7'h0) || (c && (w || sz != SIZE_16));
        cw = {w, a, c, sp, sz, inc, n};
        e0 = errs;
        txq.delete();
        rdq.delete();
        wq.delete();
        send(cw[7:0]);
        send(cw[15:8]);
        if (a) begin
            send(ad[7:0]);
            send(ad[15:8]);
            if (!bad) ptr[sp] = ad;
        end
        for (int k = 0; k < n; k++) begin
            d = 64'h0;
            for (int b = 0; b < nb && w; b++) begin
                d[b*8 +: 8] = 8'($random(seed));
                send(d[b*8 +: 8]);
            end
            if (!bad) begin
                if (w) ew.push_back({sp, sz, ptr[sp], d});
                else if (c) d = info(sp, ptr[sp]);
                else begin
                    er.push_back({sp, sz, ptr[sp]});
                    d = pat(sp, ptr[sp]);
                end
                for (int b = 0; b < nb && !w; b++) et.push_back(d[b*8 +: 8]);
                if (inc) ptr[sp] += 16'(nb);
            end
        end
        rx_valid = 1'b0;
        t = 0;
        while ((txq.size() < et.size() || rdq.size() < er.size() ||
                wq.size() < ew.size()) && t < 3000) begin
            @(posedge clock);
            #2;
            t++;
        end
        if (t >= 3000) mismatches++;
        repeat (4) @(posedge clock);
        #2;
        check(errs - e0, bad);
        check(txq.size(), et.size());
        check(rdq.size(), er.size());
        check(wq.size(), ew.size());
        for (int i = 0; i < et.size() && i < txq.size(); i++) begin
            check(txq[i], et[i]);
        end
        for (int i = 0; i < er.size() && i < rdq.size(); i++) begin
            check(rdq[i], er[i]);
        end
        for (int i = 0; i < ew.size() && i < wq.size(); i++) begin
            check(wq[i][84:64], ew[i][84:64]);
            check(wq[i][63:0] & m, ew[i][63:0]);
        end
    endtask

    initial begin
        seed = 52063;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rst_b = 1'b0;
        foreach (ptr[i]) ptr[i] = 16'h0000;
        repeat (20) @(posedge clock);
        #1;
        check(rx_ready, 1'b0);
        #1 rst_b = 1'b1;
        @(posedge clock);
        #2;
        run(1, 1, 0, 3'h0, SIZE_8, 1, 7'h03, 16'h0010);
        run(0, 0, 0, 3'h0, SIZE_8, 1, 7'h02, 16'h0000);
        run(1, 0, 0, 3'h1, SIZE_32, 0, 7'h02, 16'h0000);
        $display("test pointer done");
        for (int s = 0; s < 4; s++) begin
            run(0, 1, 0, 3'(s + 4), 2'(s), 1, 7'h02, 16'h0021);
            run(1, 0, 0, 3'(s + 4), 2'(s), 1, 7'h02, 16'h0000);
        end
        $display("test sizes done");
        for (int s = 0; s < 8; s++) begin
            run(0, 1, 1, 3'(s), SIZE_16, 1, 7'h08, 16'h0000);
            run(0, 0, 1, 3'(s), SIZE_16, 1, 7'h02, 16'h0000);
        end
        run(0, 1, 1, 3'h5, SIZE_16, 0, 7'h02, 16'h0007);
        $display("test info done");
        run(0, 1, 0, 3'h2, SIZE_16, 1, 7'h00, 16'h0044);
        run(1, 0, 1, 3'h4, SIZE_16, 1, 7'h01, 16'h0000);
        run(0, 0, 1, 3'h4, SIZE_32, 1, 7'h01, 16'h0000);
        run(1, 1, 0, 3'h6, SIZE_8, 1, 7'h00, 16'h0001);
        run(0, 0, 0, 3'h2, SIZE_8, 1, 7'h01, 16'h0000);
        run(0, 1, 0, 3'h7, SIZE_8, 1, 7'h7F, 16'h0000);
        $display("test refusals done");
        rst_b = 1'b0;
        foreach (ptr[i]) ptr[i] = 16'h0000;
        repeat (3) @(posedge clock);
        #1;
        check(rx_ready, 1'b0);
        #1 rst_b = 1'b1;
        @(posedge clock);
        #2;
        check(rx_ready, 1'b1);
        run(0, 0, 0, 3'h0, SIZE_16, 1, 7'h01, 16'h0000);
        $display("test reset done");
        repeat (60) begin
            r = $random(seed);
            run(r[0], r[1], r[2], r[12:10], r[5:4], r[3],
                (r[8] && r[9]) ? 7'h0 : 7'(r[7:6]) + 7'h1,
                r[2] ? {11'h0, r[13:9]} : r[31:16]);
        end
        $display("test random done");
        conclude();
    end

    initial begin
        #(25 * 80000);
        mismatches++;
        conclude();
    end
endmodule
`default_nettype wire
